/* File: common/asf_pkg.sv */
package asf_pkg;
	// ==========================================================
	// bus and sizes
	localparam int ASF_AW = 8;
	localparam int ASF_DW = 24;
	localparam int ASF_NSETUP = 8;
	localparam int ASF_NCH = 16;
	localparam int ASF_CHW = 4;
	localparam int ASF_SETW = 3;
	// ==========================================================
	// register map (register index on the port)
	localparam logic [7:0] ASF_SETUP0_OFS = 8'h21;
	localparam logic [7:0] ASF_SETUP7_OFS = 8'h28;
	localparam logic [7:0] ASF_CTRL_OFS = 8'h40;
	localparam logic [7:0] ASF_STATUS_OFS = 8'h41;
	// ==========================================================
	// setup register fields
	localparam int ASF_SETTLE_LSB = 21;
	localparam int ASF_REPEAT_LSB = 16;
	localparam int ASF_FTYPE_LSB = 12;
	localparam int ASF_RSVD_BIT = 11;
	localparam int ASF_RATE_LSB = 0;
	localparam logic [2:0] ASF_SETTLE_RST = 3'h0;
	localparam logic [4:0] ASF_REPEAT_RST = 5'h00;
	localparam logic [3:0] ASF_FTYPE_RST = 4'h2;
	localparam logic [10:0] ASF_RATE_RST = 11'h030;
	localparam logic [10:0] ASF_RATE_ZERO = 11'h000;
	localparam logic [10:0] ASF_RATE_ONE = 11'h001;
	// ==========================================================
	// control register fields
	localparam int ASF_CTRL_SEQ_EN = 0;
	localparam int ASF_CTRL_DUTY = 1;
	localparam int ASF_CTRL_CAL = 2;
	localparam logic [2:0] ASF_CTRL_RST = 3'h0;
	// ==========================================================
	// filter type codes
	localparam logic [3:0] ASF_FT_SINC4 = 4'h0;
	localparam logic [3:0] ASF_FT_SINC4_AVG = 4'h1;
	localparam logic [3:0] ASF_FT_SINC3 = 4'h2;
	localparam logic [3:0] ASF_FT_SINC3_NOTCH = 4'h3;
	localparam logic [3:0] ASF_FT_SINC3_AVG = 4'h4;
	localparam logic [3:0] ASF_FT_POST1 = 4'h5;
	localparam logic [3:0] ASF_FT_POST4 = 4'h8;
	// ==========================================================
	// settling wait: shortest wait in master clock cycles, doubled per code step
	localparam int ASF_SETTLE_CW = 13;
	localparam logic [12:0] ASF_SETTLE_MIN_CYC = 13'h0020;
	// ==========================================================
	typedef struct packed {
		logic [2:0] settle_code;
		logic [4:0] repeat_cnt;
		logic [3:0] filt_type;
		logic [10:0] rate_word;
	} asf_cfg_s;
endpackage

/* File: common/asf_settle_if.sv */
`timescale 1ns/100ps
interface asf_settle_if;
	logic start;
	logic [2:0] code;
	logic busy;
	logic done;
	modport timer (input start, input code, output busy, output done);
	modport ctl (output start, output code, input busy, input done);
endinterface

/* File: common/asf_setup_if.sv */
`timescale 1ns/100ps
interface asf_setup_if;
	logic wr;
	logic [23:0] wdata;
	asf_pkg::asf_cfg_s cfg;
	modport reg_side (input wr, input wdata, output cfg);
	modport ctl (output wr, output wdata, input cfg);
endinterface

/* File: rtl/asf_settle_timer.sv */
`timescale 1ns/100ps
module asf_settle_timer (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic mclk_tick,
	asf_settle_if.timer tif
);
	// ==========================================================
	// counts master clock ticks down from the selected wait
	logic [asf_pkg::ASF_SETTLE_CW-1:0] cnt_reg;
	logic [asf_pkg::ASF_SETTLE_CW-1:0] cnt_next;
	logic busy_reg;
	logic busy_next;
	logic done_reg;
	logic done_next;

	always_comb begin
		cnt_next = cnt_reg;
		busy_next = busy_reg;
		done_next = 1'b0;
		if (tif.start) begin
			cnt_next = asf_pkg::ASF_SETTLE_MIN_CYC << tif.code;
			busy_next = 1'b1;
		end else if (busy_reg && mclk_tick) begin
			cnt_next = cnt_reg - 13'h0001;
			if (cnt_reg == 13'h0001) begin
				busy_next = 1'b0;
				done_next = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cnt_reg <= 13'h0000;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
		end
	end

	assign tif.busy = busy_reg;
	assign tif.done = done_reg;
endmodule

/* File: rtl/asf_setup_reg.sv */
`timescale 1ns/100ps
module asf_setup_reg (
	input wire logic core_clk,
	input wire logic sys_rst,
	asf_setup_if.reg_side sif
);
	// ==========================================================
	// one setup register; reserved bit is not stored and so reads zero
	asf_pkg::asf_cfg_s cfg_reg;
	asf_pkg::asf_cfg_s cfg_next;

	always_comb begin
		cfg_next = cfg_reg;
		if (sif.wr) begin
			cfg_next.settle_code = sif.wdata[asf_pkg::ASF_SETTLE_LSB +: 3];
			cfg_next.repeat_cnt = sif.wdata[asf_pkg::ASF_REPEAT_LSB +: 5];
			cfg_next.filt_type = sif.wdata[asf_pkg::ASF_FTYPE_LSB +: 4];
			cfg_next.rate_word = sif.wdata[asf_pkg::ASF_RATE_LSB +: 11];
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cfg_reg <= '{asf_pkg::ASF_SETTLE_RST, asf_pkg::ASF_REPEAT_RST,
				asf_pkg::ASF_FTYPE_RST, asf_pkg::ASF_RATE_RST};
		end else begin
			cfg_reg <= cfg_next;
		end
	end

	assign sif.cfg = cfg_reg;
endmodule

/* File: rtl/asf_top.sv */
`timescale 1ns/100ps
module asf_top (
	core_clk,
	sys_rst,
	reg_addr,
	reg_wdata,
	reg_wr,
	reg_rd,
	reg_rdata,
	mclk_tick,
	chan_enable,
	chan_setup_sel,
	conv_done,
	conv_start,
	active_chan,
	active_setup,
	filt_order4,
	filt_avg,
	extra_notch_mode,
	post_filter_sel,
	rate_word,
	settling,
	seq_busy
);
	input wire logic core_clk;
	input wire logic sys_rst;
	input wire logic [asf_pkg::ASF_AW-1:0] reg_addr;
	input wire logic [asf_pkg::ASF_DW-1:0] reg_wdata;
	input wire logic reg_wr;
	input wire logic reg_rd;
	output logic [asf_pkg::ASF_DW-1:0] reg_rdata;
	input wire logic mclk_tick;
	input wire logic [asf_pkg::ASF_NCH-1:0] chan_enable;
	input wire logic [asf_pkg::ASF_NCH*asf_pkg::ASF_SETW-1:0] chan_setup_sel;
	input wire logic conv_done;
	output logic conv_start;
	output logic [asf_pkg::ASF_CHW-1:0] active_chan;
	output logic [asf_pkg::ASF_SETW-1:0] active_setup;
	output logic filt_order4;
	output logic filt_avg;
	output logic extra_notch_mode;
	output logic [2:0] post_filter_sel;
	output logic [10:0] rate_word;
	output logic settling;
	output logic seq_busy;

	typedef enum logic [2:0] {
		ASF_IDLE,
		ASF_PICK,
		ASF_SETTLE,
		ASF_CONVERT,
		ASF_WAIT
	} asf_state_e;

	// ==========================================================
	// setup registers
	asf_pkg::asf_cfg_s cfg [asf_pkg::ASF_NSETUP];
	logic in_setup_range;
	logic [asf_pkg::ASF_SETW-1:0] setup_idx;

	assign in_setup_range = (reg_addr >= asf_pkg::ASF_SETUP0_OFS) && (reg_addr <= asf_pkg::ASF_SETUP7_OFS);
	assign setup_idx = asf_pkg::ASF_SETW'(reg_addr - asf_pkg::ASF_SETUP0_OFS);

	for (genvar g = 0; g < asf_pkg::ASF_NSETUP; g++) begin : g_setup
		asf_setup_if sif ();
		assign sif.wr = reg_wr && in_setup_range && (setup_idx == asf_pkg::ASF_SETW'(g));
		assign sif.wdata = reg_wdata;
		assign cfg[g] = sif.cfg;
		asf_setup_reg u_setup (
			.core_clk(core_clk),
			.sys_rst(sys_rst),
			.sif(sif)
		);
	end

	// ==========================================================
	// control register
	logic [2:0] ctrl_reg;
	logic [2:0] ctrl_next;
	logic seq_en;
	logic once_only;

	always_comb begin
		ctrl_next = ctrl_reg;
		if (reg_wr && (reg_addr == asf_pkg::ASF_CTRL_OFS)) begin
			ctrl_next = reg_wdata[2:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ctrl_reg <= asf_pkg::ASF_CTRL_RST;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	assign seq_en = ctrl_reg[asf_pkg::ASF_CTRL_SEQ_EN];
	assign once_only = ctrl_reg[asf_pkg::ASF_CTRL_DUTY] | ctrl_reg[asf_pkg::ASF_CTRL_CAL];

	// ==========================================================
	// settling timer
	asf_settle_if tif ();

	asf_settle_timer u_timer (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.mclk_tick(mclk_tick),
		.tif(tif)
	);

	// ==========================================================
	// sequencer
	asf_state_e state_reg;
	asf_state_e state_next;
	logic [asf_pkg::ASF_CHW-1:0] chan_reg;
	logic [asf_pkg::ASF_CHW-1:0] chan_next;
	logic [asf_pkg::ASF_SETW-1:0] setup_reg;
	logic [asf_pkg::ASF_SETW-1:0] setup_next;
	logic last_valid_reg;
	logic last_valid_next;
	logic [4:0] rep_left_reg;
	logic [4:0] rep_left_next;
	logic start_reg;
	logic start_next;
	logic [asf_pkg::ASF_CHW-1:0] found_chan;
	logic found_any;
	asf_pkg::asf_cfg_s pick_cfg;
	asf_pkg::asf_cfg_s cur_cfg;
	logic [asf_pkg::ASF_SETW-1:0] pick_setup;

	// round robin: search the enabled channels starting after the current one
	always_comb begin
		logic [asf_pkg::ASF_CHW-1:0] cand;
		cand = '0;
		found_chan = chan_reg;
		found_any = 1'b0;
		for (int i = asf_pkg::ASF_NCH; i >= 1; i--) begin
			cand = chan_reg + asf_pkg::ASF_CHW'(i);
			if (chan_enable[cand]) begin
				found_chan = cand;
				found_any = 1'b1;
			end
		end
	end

	assign pick_setup = chan_setup_sel[found_chan*asf_pkg::ASF_SETW +: asf_pkg::ASF_SETW];
	assign pick_cfg = cfg[pick_setup];
	assign cur_cfg = cfg[setup_reg];

	always_comb begin
		state_next = state_reg;
		chan_next = chan_reg;
		setup_next = setup_reg;
		last_valid_next = last_valid_reg;
		rep_left_next = rep_left_reg;
		start_next = 1'b0;
		tif.start = 1'b0;
		tif.code = pick_cfg.settle_code;
		unique case (state_reg)
			ASF_IDLE: begin
				if (seq_en && found_any) begin
					state_next = ASF_PICK;
				end
			end
			ASF_PICK: begin
				if (!seq_en || !found_any) begin
					state_next = ASF_IDLE;
				end else begin
					chan_next = found_chan;
					setup_next = pick_setup;
					rep_left_next = once_only ? 5'h00 : pick_cfg.repeat_cnt;
					last_valid_next = 1'b1;
					if (!last_valid_reg || (found_chan != chan_reg)) begin
						tif.start = 1'b1;
						state_next = ASF_SETTLE;
					end else begin
						state_next = ASF_CONVERT;
					end
				end
			end
			ASF_SETTLE: begin
				if (!seq_en) begin
					state_next = ASF_IDLE;
					last_valid_next = 1'b0;
				end else if (tif.done) begin
					state_next = ASF_CONVERT;
				end
			end
			ASF_CONVERT: begin
				start_next = 1'b1;
				state_next = ASF_WAIT;
			end
			ASF_WAIT: begin
				if (conv_done) begin
					if (!seq_en) begin
						state_next = ASF_IDLE;
					end else if (rep_left_reg != 5'h00 && !once_only) begin
						rep_left_next = rep_left_reg - 5'h01;
						state_next = ASF_CONVERT;
					end else begin
						state_next = ASF_PICK;
					end
				end
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_reg <= ASF_IDLE;
			chan_reg <= '1;
			setup_reg <= '0;
			last_valid_reg <= 1'b0;
			rep_left_reg <= 5'h00;
			start_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			chan_reg <= chan_next;
			setup_reg <= setup_next;
			last_valid_reg <= last_valid_next;
			rep_left_reg <= rep_left_next;
			start_reg <= start_next;
		end
	end

	// ==========================================================
	// filter decode, latched with each conversion start
	logic ord4_reg;
	logic ord4_next;
	logic avg_reg;
	logic avg_next;
	logic notch_reg;
	logic notch_next;
	logic [2:0] post_reg;
	logic [2:0] post_next;
	logic [10:0] rate_reg;
	logic [10:0] rate_next;
	logic [asf_pkg::ASF_CHW-1:0] achan_reg;
	logic [asf_pkg::ASF_CHW-1:0] achan_next;
	logic [asf_pkg::ASF_SETW-1:0] aset_reg;
	logic [asf_pkg::ASF_SETW-1:0] aset_next;

	// reserved types fall back to plain sinc3; software must not write them
	always_comb begin
		ord4_next = ord4_reg;
		avg_next = avg_reg;
		notch_next = notch_reg;
		post_next = post_reg;
		rate_next = rate_reg;
		achan_next = achan_reg;
		aset_next = aset_reg;
		if (state_reg == ASF_CONVERT) begin
			achan_next = chan_reg;
			aset_next = setup_reg;
			ord4_next = (cur_cfg.filt_type == asf_pkg::ASF_FT_SINC4) ||
				(cur_cfg.filt_type == asf_pkg::ASF_FT_SINC4_AVG);
			avg_next = (cur_cfg.filt_type == asf_pkg::ASF_FT_SINC4_AVG) ||
				(cur_cfg.filt_type == asf_pkg::ASF_FT_SINC3_AVG);
			notch_next = (cur_cfg.filt_type == asf_pkg::ASF_FT_SINC3_NOTCH);
			if (cur_cfg.filt_type >= asf_pkg::ASF_FT_POST1 && cur_cfg.filt_type <= asf_pkg::ASF_FT_POST4) begin
				post_next = 3'(cur_cfg.filt_type - asf_pkg::ASF_FT_POST1) + 3'h1;
			end else begin
				post_next = 3'h0;
			end
			if (cur_cfg.rate_word == asf_pkg::ASF_RATE_ZERO) begin
				rate_next = asf_pkg::ASF_RATE_ONE;
			end else begin
				rate_next = cur_cfg.rate_word;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ord4_reg <= 1'b0;
			avg_reg <= 1'b0;
			notch_reg <= 1'b0;
			post_reg <= 3'h0;
			rate_reg <= asf_pkg::ASF_RATE_RST;
			achan_reg <= '0;
			aset_reg <= '0;
		end else begin
			ord4_reg <= ord4_next;
			avg_reg <= avg_next;
			notch_reg <= notch_next;
			post_reg <= post_next;
			rate_reg <= rate_next;
			achan_reg <= achan_next;
			aset_reg <= aset_next;
		end
	end

	// ==========================================================
	// read port and status flags
	logic [asf_pkg::ASF_DW-1:0] rdata_reg;
	logic [asf_pkg::ASF_DW-1:0] rdata_next;
	logic settling_reg;
	logic settling_next;
	logic busy_reg;
	logic busy_next;
	asf_pkg::asf_cfg_s rd_cfg;

	assign rd_cfg = cfg[setup_idx];

	always_comb begin
		rdata_next = '0;
		settling_next = (state_next == ASF_SETTLE);
		busy_next = (state_next != ASF_IDLE);
		if (reg_rd) begin
			if (in_setup_range) begin
				rdata_next = {rd_cfg.settle_code, rd_cfg.repeat_cnt, rd_cfg.filt_type,
					1'b0, rd_cfg.rate_word};
			end else if (reg_addr == asf_pkg::ASF_CTRL_OFS) begin
				rdata_next = {21'h000000, ctrl_reg};
			end else if (reg_addr == asf_pkg::ASF_STATUS_OFS) begin
				rdata_next = {10'h000, rep_left_reg, setup_reg, chan_reg, settling_reg, busy_reg};
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rdata_reg <= '0;
			settling_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			settling_reg <= settling_next;
			busy_reg <= busy_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign conv_start = start_reg;
	assign active_chan = achan_reg;
	assign active_setup = aset_reg;
	assign filt_order4 = ord4_reg;
	assign filt_avg = avg_reg;
	assign extra_notch_mode = notch_reg;
	assign post_filter_sel = post_reg;
	assign rate_word = rate_reg;
	assign settling = settling_reg;
	assign seq_busy = busy_reg;
endmodule

/* File: testbench/asf_top_assertions.sv */
`timescale 1ns/100ps
module asf_top_assertions (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [23:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [23:0] reg_rdata,
	input wire logic mclk_tick,
	input wire logic [15:0] chan_enable,
	input wire logic [47:0] chan_setup_sel,
	input wire logic conv_done,
	input wire logic conv_start,
	input wire logic [3:0] active_chan,
	input wire logic [2:0] active_setup,
	input wire logic filt_order4,
	input wire logic filt_avg,
	input wire logic extra_notch_mode,
	input wire logic [2:0] post_filter_sel,
	input wire logic [10:0] rate_word,
	input wire logic settling,
	input wire logic seq_busy
);
	// ==========================================================
	// master ticks seen while settling; 13 bits hold the longest wait
	logic [12:0] tick_reg;
	logic [12:0] tick_next;
	always_comb begin
		tick_next = tick_reg;
		if (!settling)
			tick_next = 13'h0000;
		else if (mclk_tick)
			tick_next = tick_reg + 13'h0001;
	end
	always_ff @(posedge core_clk) begin
		if (sys_rst)
			tick_reg <= 13'h0000;
		else
			tick_reg <= tick_next;
	end
	// ==========================================================
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	start_pulse_a: assert property (conv_start |=> !conv_start)
		else $error("conversion start longer than one cycle");
	start_clear_a: assert property (conv_start |-> !settling && seq_busy)
		else $error("conversion start during settling");
	settle_span_a: assert property ($fell(settling) |-> tick_reg >= 13'h001E && tick_reg <= 13'h1003)
		else $error("settling wait outside 32 to 4096 ticks");
	settle_then_start_a: assert property ($fell(settling) && seq_busy |-> ##[0:3] conv_start)
		else $error("no conversion after settling");
	settle_busy_a: assert property (settling |-> seq_busy)
		else $error("settling while idle");
	rate_nonzero_a: assert property (rate_word != 11'h000)
		else $error("rate word shows zero");
	notch_decode_a: assert property (extra_notch_mode |-> !filt_order4 && !filt_avg && post_filter_sel == 3'h0)
		else $error("notch mode mixed with other filter");
	order4_decode_a: assert property (filt_order4 |-> post_filter_sel == 3'h0 && !extra_notch_mode)
		else $error("fourth order mixed with other filter");
	post_range_a: assert property (post_filter_sel != 3'h0 |-> post_filter_sel <= 3'h4 && !filt_avg && !filt_order4)
		else $error("post filter select out of range");
	rsvd_bit_a: assert property (reg_rd && reg_addr >= asf_pkg::ASF_SETUP0_OFS && reg_addr <= asf_pkg::ASF_SETUP7_OFS
		|=> !reg_rdata[11])
		else $error("reserved setup bit reads one");
endmodule

/* File: testbench/asf_top_tb.sv */
`timescale 1ns/100ps
module asf_top_tb;
	typedef struct packed {
		logic [3:0] chan;
		logic [2:0] setup;
		logic o4;
		logic avg;
		logic notch;
		logic [2:0] post;
		logic [10:0] rate;
		int ticks;
	} asf_exp_s;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [23:0] reg_wdata = 24'h000000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic mclk_tick = 1'b0;
	logic [15:0] chan_enable = 16'h0000;
	logic [47:0] chan_setup_sel = 48'h000000000000;
	logic conv_done = 1'b0;
	logic [23:0] reg_rdata;
	logic conv_start;
	logic [3:0] active_chan;
	logic [2:0] active_setup;
	logic filt_order4;
	logic filt_avg;
	logic extra_notch_mode;
	logic [2:0] post_filter_sel;
	logic [10:0] rate_word;
	logic settling;
	logic seq_busy;
	int mismatches = 0;
	int check_count = 0;
	int n_cv = 0;
	int tk = 0;
	int tk_s = 0;
	bit rd_d = 0;
	bit cs_d = 0;
	logic [23:0] rd_q[$];
	asf_exp_s cv_q[$];
	logic [23:0] img [8];

	asf_top dut (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mclk_tick,
		.chan_enable, .chan_setup_sel, .conv_done, .conv_start, .active_chan, .active_setup, .filt_order4,
		.filt_avg, .extra_notch_mode, .post_filter_sel, .rate_word, .settling, .seq_busy);

	initial forever #12.5 core_clk = ~core_clk;
	// dense random ticks so the longest wait stays short in cycles
	always @(posedge core_clk) mclk_tick <= ($urandom % 4) != 0;

	// ==========================================================
	// reporting
	task automatic fail(input string msg);
		mismatches++;
		$display("Error %0t: %s", $time, msg);
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk_rd(input logic [23:0] e);
		check_count++;
		if (reg_rdata !== e)
			fail($sformatf("read %h expected %h", reg_rdata, e));
	endtask
	task automatic chk_cv(input asf_exp_s e, input int t);
		check_count++;
		if ({active_chan, active_setup, filt_order4, filt_avg, extra_notch_mode, post_filter_sel, rate_word} !==
				{e.chan, e.setup, e.o4, e.avg, e.notch, e.post, e.rate} || t < e.ticks - 2 || t > e.ticks + 3 ||
				(e.ticks == 0 && t != 0))
			fail($sformatf("conversion ch %0d ticks %0d expected %0d", active_chan, t, e.ticks));
	endtask
	task automatic chk_idle;
		check_count++;
		if (seq_busy !== 1'b0 || settling !== 1'b0 || conv_start !== 1'b0)
			fail("sequencer not idle after stop");
	endtask

	// ==========================================================
	// bus master
	task automatic wr(input logic [7:0] a, input logic [23:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [23:0] e);
		@(posedge core_clk);
		rd_q.push_back(e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
	endtask

	function automatic asf_exp_s ex(input int ch, input int s, input bit first);
		logic [3:0] t;
		t = img[s][15:12];
		ex.chan = 4'(ch);
		ex.setup = 3'(s);
		ex.o4 = t <= 4'h1;
		ex.avg = t == 4'h1 || t == 4'h4;
		ex.notch = t == 4'h3;
		ex.post = (t >= 4'h5 && t <= 4'h8) ? 3'(t - 4'h4) : 3'h0;
		ex.rate = img[s][10:0] == 11'h000 ? 11'h001 : img[s][10:0];
		ex.ticks = first ? 32 << img[s][23:21] : 0;
	endfunction

	// ==========================================================
	// result watcher and converter stand-in
	always @(posedge core_clk) begin
		if (rd_d)
			chk_rd(rd_q.pop_front());
		rd_d = reg_rd;
		if (cs_d) begin
			n_cv++;
			if (cv_q.size() == 0)
				fail("unexpected conversion");
			else
				chk_cv(cv_q.pop_front(), tk_s);
		end
		cs_d = conv_start && !sys_rst;
		if (conv_start) begin
			tk_s = tk;
			tk = 0;
		end else if (settling && mclk_tick)
			tk++;
	end
	initial forever begin
		@(posedge core_clk);
		if (conv_start) begin
			repeat (4 + $urandom % 4) @(posedge core_clk);
			conv_done <= 1'b1;
			@(posedge core_clk);
			conv_done <= 1'b0;
		end
	end
	initial begin
		repeat (100000) @(posedge core_clk);
		fail("timeout");
		results();
	end

	// ==========================================================
	// tests
	initial begin
		int a;
		int n;
		int tgt;
		int c;
		logic [2:0] ctl;
		void'($urandom(32'h614AB729));
		repeat (6) @(posedge core_clk);
		sys_rst <= 1'b0;
		for (int s = 0; s < 8; s++)
			rd(asf_pkg::ASF_SETUP0_OFS + 8'(s), 24'h002030);
		rd(asf_pkg::ASF_CTRL_OFS, 24'h000000);
		rd(8'h20, 24'h000000);
		$display("test reset_values done");
		// settling code and filter type follow the setup index
		for (int s = 0; s < 8; s++) begin
			img[s] = {3'(s), 5'($urandom % 4), 4'(s), 1'b0, 11'($urandom)};
			if (s == 0)
				img[s][20:16] = 5'h00;
			if (s == 1)
				img[s][10:0] = 11'h000;
			if (s == 3)
				img[s][10:0] = 11'h030;
			wr(asf_pkg::ASF_SETUP0_OFS + 8'(s), img[s] | 24'h000800);
			rd(asf_pkg::ASF_SETUP0_OFS + 8'(s), img[s]);
		end
		wr(8'h20, 24'hFFFFFF);
		rd(8'h20, 24'h000000);
		$display("test setup_access done");
		for (int r = 0; r < 7; r++) begin
			a = r % 4;
			chan_enable <= r == 6 ? 16'h0001 : 16'h0003;
			ctl = r == 4 ? 3'h3 : r == 5 ? 3'h5 : 3'h1;
			if (r >= 4) begin
				img[a][20:16] = 5'h03;
				img[a][15:12] = 4'h8;
				wr(asf_pkg::ASF_SETUP0_OFS + 8'(a), img[a]);
			end
			chan_setup_sel <= 48'({3'(a + 4), 3'(a)});
			tgt = n_cv;
			for (int v = 0; v < 4; v++) begin
				c = r == 6 ? 0 : v % 2;
				n = ctl[2:1] != 2'h0 ? 1 : img[a + 4 * c][20:16] + 1;
				// a lone channel picked again keeps its settled front end
				for (int k = 0; k < n; k++)
					cv_q.push_back(ex(c, a + 4 * c, k == 0 && (r < 6 || v == 0)));
				tgt += n;
			end
			wr(asf_pkg::ASF_CTRL_OFS, 24'(ctl));
			for (int i = 0; i < 30000 && n_cv < tgt; i++)
				@(posedge core_clk);
			wr(asf_pkg::ASF_CTRL_OFS, 24'h000000);
			for (int i = 0; i < 200 && seq_busy !== 1'b0; i++)
				@(posedge core_clk);
			rd(asf_pkg::ASF_STATUS_OFS, 24'((a + 4 * c) * 64 + c * 4));
			repeat (20) @(posedge core_clk);
			chk_idle();
			if (cv_q.size() != 0)
				fail("conversions missing");
			cv_q.delete();
			$display("test sequence %0d done", r);
		end
		results();
	end
endmodule

bind asf_top asf_top_assertions chk (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.mclk_tick, .chan_enable, .chan_setup_sel, .conv_done, .conv_start, .active_chan, .active_setup, .filt_order4,
	.filt_avg, .extra_notch_mode, .post_filter_sel, .rate_word, .settling, .seq_busy);
